// >>> rtl/ltc_pkg.sv
// Constants and carrier types for the LCD timing and contrast control block.
// Assumes a single 200 MHz clock domain and an active-low asynchronous reset.
// Summary of operation
// - Timing generator derives line-address and data-latch strobes from the display clock.
// - Display data is latched and driven to segment outputs with the display clock.
// - Panel refresh reads run independently of host accesses, causing no flicker.
// - Timing generator also makes the common scan and AC polarity signals.
// - AC polarity follows a two-frame alternating pattern by default.
// - Each output selects one of four levels from data, scan and polarity.
// - Power control holds independent booster, regulator and follower enables.
// - Contrast command loads a five-bit value selecting one of 32 steps.
// - Contrast coefficient equals 31 minus the code.
// - Divider command loads three bits; 0-6 internal ratios, 7 means external.
// - Reset clears all three power enables.
// - Reset loads contrast with binary 10000.
// - Reset enters power-saving mode with oscillator and supply stopped.
package ltc_pkg;
  localparam logic [4:0] CONTRAST_RESET = 5'h10;
  localparam logic [4:0] CONTRAST_MAX = 5'h1f;
  localparam logic [2:0] DIVIDER_RESET = 3'h0;
  localparam logic [2:0] DIVIDER_EXTERNAL = 3'h7;
  localparam logic [2:0] POWER_RESET = 3'h0;
  // Command codes on the command port
  localparam logic [1:0] CMD_POWER = 2'h0;
  localparam logic [1:0] CMD_CONTRAST = 2'h1;
  localparam logic [1:0] CMD_DIVIDER = 2'h2;
  localparam logic [1:0] CMD_SAVER = 2'h3;
  // Four drive levels: index into the bias ladder
  localparam logic [1:0] LVL_V0 = 2'h0;
  localparam logic [1:0] LVL_V1V2 = 2'h1;
  localparam logic [1:0] LVL_V3V4 = 2'h2;
  localparam logic [1:0] LVL_VSS = 2'h3;

  typedef struct packed {
    logic booster;
    logic regulator;
    logic follower;
  } ltc_power_t;

  typedef struct packed {
    logic [4:0] coefficient;
    logic [2:0] divider;
    logic external_resistors;
  } ltc_volt_t;
endpackage

// >>> rtl/ltc_level_mux.sv
// Four-level drive selector for one segment or common electrode.
// Assumes inputs from logic on the same clock; output is registered.
`timescale 1ns/1ps
module ltc_level_mux
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic is_common_in,
  input wire logic select_in,
  input wire logic polarity_in,
  input wire logic blank_in,
  output logic [1:0] level_out
);
  logic [1:0] level;
  logic [1:0] next_level;

  // Level from data or scan state and polarity
  always_comb
  begin
    if (blank_in)
      next_level = ltc_pkg::LVL_VSS;
    else if (is_common_in)
      next_level = select_in ? (polarity_in ? ltc_pkg::LVL_VSS : ltc_pkg::LVL_V0)
                             : (polarity_in ? ltc_pkg::LVL_V1V2 : ltc_pkg::LVL_V3V4);
    else
      next_level = select_in ? (polarity_in ? ltc_pkg::LVL_V0 : ltc_pkg::LVL_VSS)
                             : (polarity_in ? ltc_pkg::LVL_V3V4 : ltc_pkg::LVL_V1V2);
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      level <= ltc_pkg::LVL_VSS;
    else
      level <= next_level;
  end

  assign level_out = level;
endmodule

// >>> rtl/ltc_timing_ctrl.sv
// Display timing generator, LCD drive level selection and power/contrast settings.
// Assumes the display clock is a one-cycle enable from the same 200 MHz domain and
// that line data arrive already read from display memory by a separate port.
`timescale 1ns/1ps
module ltc_timing_ctrl
#(
  parameter int ROWS = 65,
  parameter int COLS = 132,
  parameter int CLKS_PER_LINE = 4
)
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic display_clock_in,
  input wire logic [COLS-1:0] line_data_in,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_code_in,
  input wire logic [4:0] cmd_data_in,
  output logic [$clog2(ROWS)-1:0] line_address_out,
  output logic line_strobe_out,
  output logic latch_strobe_out,
  output logic panel_ac_polarity_out,
  output logic [ROWS-1:0] common_row_output_out,
  output logic [2*COLS-1:0] segment_column_output_out,
  output logic [2*ROWS-1:0] common_level_out,
  output ltc_pkg::ltc_power_t power_enable_out,
  output logic [4:0] contrast_step_out,
  output ltc_pkg::ltc_volt_t lcd_drive_voltage_out,
  output logic power_saver_out
);
  localparam int RW = $clog2(ROWS);
  localparam int DW = $clog2(CLKS_PER_LINE + 1);

  initial
  begin
    if (ROWS < 2 || COLS < 1 || CLKS_PER_LINE < 2)
      $error("ltc_timing_ctrl: unsupported parameters");
  end

  // Timing state
  logic [DW-1:0] div_count, next_div_count;
  logic [RW-1:0] row, next_row;
  logic polarity, next_polarity;
  logic line_strobe, next_line_strobe;
  logic latch_strobe, next_latch_strobe;
  logic [ROWS-1:0] common_row, next_common_row;
  logic [COLS-1:0] latched, next_latched;
  // Settings state
  ltc_pkg::ltc_power_t power, next_power;
  logic [4:0] contrast_step, next_contrast_step;
  logic [2:0] divider_ratio_select, next_divider_ratio_select;
  logic saver, next_saver;
  // Registered copy of the enables as seen on the pins, zero in saver
  ltc_pkg::ltc_power_t power_out, next_power_out;
  ltc_pkg::ltc_volt_t volt, next_volt;

  // Timing next-state: display clock enables drive everything; saver halts it
  always_comb
  begin
    next_div_count = div_count;
    next_row = row;
    next_polarity = polarity;
    next_line_strobe = 1'b0;
    next_latch_strobe = 1'b0;
    next_common_row = common_row;
    next_latched = latched;
    // Looks at the saver value being loaded so the scan parks in the same edge
    if (next_saver)
    begin
      // Oscillator stopped: no strobes, scan parked
      next_div_count = '0;
      next_common_row = '0;
    end
    else if (display_clock_in)
    begin
      if (div_count == DW'(CLKS_PER_LINE - 1))
      begin
        next_div_count = '0;
        next_line_strobe = 1'b1;
        next_latch_strobe = 1'b1;
        // Latch only at line boundary so host traffic never shows mid-line
        next_latched = line_data_in;
        next_common_row = '0;
        next_common_row[row] = 1'b1;
        if (row == RW'(ROWS - 1))
        begin
          next_row = '0;
          next_polarity = ~polarity;
        end
        else
          next_row = row + RW'(1);
      end
      else
        next_div_count = div_count + DW'(1);
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      div_count <= '0;
      row <= '0;
      polarity <= 1'b0;
      line_strobe <= 1'b0;
      latch_strobe <= 1'b0;
      common_row <= '0;
      latched <= '0;
    end
    else
    begin
      div_count <= next_div_count;
      row <= next_row;
      polarity <= next_polarity;
      line_strobe <= next_line_strobe;
      latch_strobe <= next_latch_strobe;
      common_row <= next_common_row;
      latched <= next_latched;
    end
  end

  // Command decode; the host is trusted to keep to the sensible enable sets
  always_comb
  begin
    next_power = power;
    next_contrast_step = contrast_step;
    next_divider_ratio_select = divider_ratio_select;
    next_saver = saver;
    if (cmd_valid_in)
    begin
      unique case (cmd_code_in)
        ltc_pkg::CMD_POWER:
        begin
          // Any combination is stored as written
          next_power.booster = cmd_data_in[2];
          next_power.regulator = cmd_data_in[1];
          next_power.follower = cmd_data_in[0];
        end
        ltc_pkg::CMD_CONTRAST: next_contrast_step = cmd_data_in;
        ltc_pkg::CMD_DIVIDER: next_divider_ratio_select = cmd_data_in[2:0];
        ltc_pkg::CMD_SAVER: next_saver = cmd_data_in[0];
      endcase
    end
    next_power_out = next_saver ? ltc_pkg::POWER_RESET : next_power;
    next_volt.coefficient = ltc_pkg::CONTRAST_MAX - next_contrast_step;
    next_volt.divider = next_divider_ratio_select;
    next_volt.external_resistors =
      (next_divider_ratio_select == ltc_pkg::DIVIDER_EXTERNAL);
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      power <= ltc_pkg::POWER_RESET;
      contrast_step <= ltc_pkg::CONTRAST_RESET;
      divider_ratio_select <= ltc_pkg::DIVIDER_RESET;
      saver <= 1'b1;
      power_out <= ltc_pkg::POWER_RESET;
      volt <= '{coefficient: 5'h0f, divider: 3'h0, external_resistors: 1'b0};
    end
    else
    begin
      power <= next_power;
      contrast_step <= next_contrast_step;
      divider_ratio_select <= next_divider_ratio_select;
      saver <= next_saver;
      power_out <= next_power_out;
      volt <= next_volt;
    end
  end

  // Per-electrode drive selectors; saver parks outputs at ground level
  genvar gi;
  generate
    for (gi = 0; gi < COLS; gi++)
    begin : g_seg
      ltc_level_mux u_seg (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .is_common_in(1'b0),
        .select_in(latched[gi]),
        .polarity_in(polarity),
        .blank_in(saver),
        .level_out(segment_column_output_out[2*gi +: 2])
      );
    end
    for (gi = 0; gi < ROWS; gi++)
    begin : g_com
      ltc_level_mux u_com (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .is_common_in(1'b1),
        .select_in(common_row[gi]),
        .polarity_in(polarity),
        .blank_in(saver),
        .level_out(common_level_out[2*gi +: 2])
      );
    end
  endgenerate

  // Straight register outputs
  assign line_address_out = row;
  assign line_strobe_out = line_strobe;
  assign latch_strobe_out = latch_strobe;
  assign panel_ac_polarity_out = polarity;
  assign common_row_output_out = common_row;
  assign power_enable_out = power_out;
  assign contrast_step_out = contrast_step;
  assign lcd_drive_voltage_out = volt;
  assign power_saver_out = saver;
endmodule

// >>> sim/ltc_timing_ctrl_sva.sv
// Checker for the LCD timing and contrast block.
// Assumes one clock domain; bound to every ltc_timing_ctrl instance.
`timescale 1ns/1ps
module ltc_timing_ctrl_sva
#(
  parameter int ROWS = 65
)
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_code_in,
  input wire logic [4:0] cmd_data_in,
  input wire logic [$clog2(ROWS)-1:0] line_address_out,
  input wire logic line_strobe_out,
  input wire logic latch_strobe_out,
  input wire logic panel_ac_polarity_out,
  input wire logic [ROWS-1:0] common_row_output_out,
  input wire ltc_pkg::ltc_power_t power_enable_out,
  input wire logic [4:0] contrast_step_out,
  input wire ltc_pkg::ltc_volt_t lcd_drive_voltage_out,
  input wire logic power_saver_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // Command writes land one edge after they are taken
  contrast_load_a: assert property (
    cmd_valid_in && cmd_code_in == 2'h1 |=> contrast_step_out == $past(cmd_data_in))
    else $error("contrast not loaded");
  coef_track_a: assert property (
    lcd_drive_voltage_out.coefficient == 5'h1f - contrast_step_out) else $error("bad coefficient");
  divider_load_a: assert property (
    cmd_valid_in && cmd_code_in == 2'h2 |=> lcd_drive_voltage_out.divider == $past(cmd_data_in[2:0]))
    else $error("divider not loaded");
  power_load_a: assert property (
    cmd_valid_in && cmd_code_in == 2'h0 && !power_saver_out |=>
    power_enable_out == $past(cmd_data_in[2:0])) else $error("power not loaded");
  saver_quiet_a: assert property (
    power_saver_out |-> power_enable_out == 3'h0 && common_row_output_out == '0)
    else $error("saver outputs active");
  // Strobes are single-cycle and always come as a pair
  strobe_pair_a: assert property (
    line_strobe_out |-> latch_strobe_out ##1 !line_strobe_out) else $error("strobe pair broken");
  polarity_frame_a: assert property (
    $changed(panel_ac_polarity_out) |-> line_strobe_out && line_address_out == '0)
    else $error("polarity off frame edge");
  row_step_a: assert property (
    line_strobe_out && line_address_out != '0 |-> line_address_out == $past(line_address_out) + 1'b1)
    else $error("row did not step");
  row_onehot_a: assert property (
    common_row_output_out != '0 |-> $onehot(common_row_output_out)) else $error("rows not one-hot");
  cover property ($rose(panel_ac_polarity_out));
  cover property ($fell(power_saver_out));
  cover property (power_enable_out == 3'h7);
endmodule
bind ltc_timing_ctrl ltc_timing_ctrl_sva #(.ROWS(ROWS)) i_sva (.clock_in, .rst_n_in,
  .cmd_valid_in, .cmd_code_in, .cmd_data_in, .line_address_out, .line_strobe_out,
  .latch_strobe_out, .panel_ac_polarity_out, .common_row_output_out, .power_enable_out,
  .contrast_step_out, .lcd_drive_voltage_out, .power_saver_out);

// >>> sim/ltc_panel_model.sv
// Far-side model: refresh line data for the row scanned next.
// Assumes the row address holds steady between line strobes.
`timescale 1ns/1ps
module ltc_panel_model
#(
  parameter int ROWS = 4,
  parameter int COLS = 4
)
(
  input wire logic [$clog2(ROWS)-1:0] row_in,
  output logic [COLS-1:0] data_out
);
  // Pattern differs per row, so stale data would show
  assign data_out = COLS'(row_in) ^ {COLS{row_in[0]}};
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the LCD timing and contrast block.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
module testbench;
  localparam int ROWS = 4;
  localparam int COLS = 4;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic disp = 1'b0;
  logic valid = 1'b0;
  logic [1:0] code = 2'h0;
  logic [4:0] data = 5'h0;
  logic [1:0] row;
  logic [COLS-1:0] line;
  logic pol;
  logic pol_now;
  logic stb;
  logic [ROWS-1:0] rows;
  ltc_pkg::ltc_power_t pwr;
  logic [4:0] step;
  ltc_pkg::ltc_volt_t volt;
  logic saver;
  logic lat;
  logic [2*COLS-1:0] segment_column_output;
  logic [2*ROWS-1:0] coml;
  logic [COLS-1:0] exp_line;
  logic [2:0] sets[5] = '{3'h7, 3'h3, 3'h1, 3'h0, 3'h7};
  int n_errors = 0;
  int compares = 0;
  int n;
  initial forever #2.5 clock_in = ~clock_in;
  // Display clock enable on every other cycle
  always @(posedge clock_in) disp <= ~disp;
  ltc_timing_ctrl #(.ROWS(ROWS), .COLS(COLS), .CLKS_PER_LINE(2)) i_dut (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .display_clock_in(disp), .line_data_in(line), .cmd_valid_in(valid),
    .cmd_code_in(code), .cmd_data_in(data), .line_address_out(row), .line_strobe_out(stb),
    .latch_strobe_out(lat), .panel_ac_polarity_out(pol_now), .common_row_output_out(rows),
    .segment_column_output_out(segment_column_output), .common_level_out(coml), .power_enable_out(pwr),
    .contrast_step_out(step), .lcd_drive_voltage_out(volt), .power_saver_out(saver));
  ltc_panel_model #(.ROWS(ROWS), .COLS(COLS)) i_panel (.row_in(row), .data_out(line));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One command pulse; registers settle one edge later
  task automatic send(input logic [1:0] c, input logic [4:0] d);
    @(posedge clock_in);
    valid <= 1'b1;
    code <= c;
    data <= d;
    @(posedge clock_in);
    valid <= 1'b0;
    #1;
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard, far beyond the fewer than two hundred cycles needed
  initial
  begin
    #20000;
    n_errors++;
    complete_run();
  end
  initial
  begin
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    #1;
    check(step, 8'h10, "contrast");
    check(pwr, 8'h0, "power");
    check(saver, 8'h1, "saver");
    for (int c = 0; c < 32; c++)
    begin
      send(ltc_pkg::CMD_CONTRAST, 5'(c));
      check(step, 8'(c), "contrast");
      check(volt.coefficient, 8'(31 - c), "coefficient");
    end
    for (int d = 0; d < 8; d++)
    begin
      send(ltc_pkg::CMD_DIVIDER, 5'(d));
      check(volt.divider, 8'(d), "divider");
      check(volt.external_resistors, 8'(d == 7), "external");
    end
    send(ltc_pkg::CMD_SAVER, 5'h0);
    foreach (sets[i])
    begin
      send(ltc_pkg::CMD_POWER, {2'h0, sets[i]});
      check(pwr, sets[i], "power");
    end
    // Count line strobes over one whole frame
    @(pol_now);
    #1;
    pol = pol_now;
    n = 0;
    do
    begin
      @(posedge clock_in);
      #1;
      n += stb;
    end
    while (pol_now === pol && n < 99);
    check(8'(n), 8'(ROWS), "lines per frame");
    // Levels show one edge after the line strobe that latched the row
    while (stb !== 1'b1)
    begin
      @(posedge clock_in);
      #1;
    end
    check(lat, 8'h1, "latch strobe");
    n = 0;
    for (int r = 0; r < ROWS; r++)
      if (rows[r])
        n = r;
    check(row, 8'((n + 1) % ROWS), "line address");
    exp_line = COLS'(n) ^ {COLS{n[0]}};
    pol = pol_now;
    @(posedge clock_in);
    #1;
    for (int i = 0; i < COLS; i++)
    begin
      check(segment_column_output[2*i +: 2], exp_line[i] ? (pol ? ltc_pkg::LVL_V0 : ltc_pkg::LVL_VSS)
        : (pol ? ltc_pkg::LVL_V3V4 : ltc_pkg::LVL_V1V2), "segment level");
    end
    check(coml[2*n +: 2], pol ? ltc_pkg::LVL_VSS : ltc_pkg::LVL_V0, "common level");
    send(ltc_pkg::CMD_SAVER, 5'h1);
    #20;
    check(pwr, 8'h0, "power in saver");
    check(rows, 8'h0, "rows in saver");
    complete_run();
  end
endmodule
